/* File: ubtrc_pkg.sv */
/*
  Shared constants and types for the UART rate, transmit and receive core.
  Assumes a single 100 MHz system clock that also stands in for the
  oscillator input.
*/
package ubtrc_pkg;
  // Register addresses on the 3-bit register port
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IER  = 3'h1;
  localparam logic [2:0] ADDR_FCR  = 3'h2;
  localparam logic [2:0] ADDR_LCR  = 3'h3;
  localparam logic [2:0] ADDR_MCR  = 3'h4;
  localparam logic [2:0] ADDR_LSR  = 3'h5;
  // Field positions
  localparam int MCR_PRESCALE = 7;
  localparam int FCR_FIFO_EN  = 0;
  localparam int FCR_RX_FLUSH = 1;
  localparam int FCR_TX_FLUSH = 2;
  localparam int FCR_TRIG_LSB = 6;
  localparam int IER_RX       = 0;
  localparam int IER_TX       = 1;
  localparam int LCR_STOP2    = 2;
  localparam int LCR_PAR_EN   = 3;
  localparam int LCR_EVEN     = 4;
  localparam int LCR_DLAB     = 7;
  // Reset values
  localparam logic [7:0] IER_RST      = 8'h00;
  localparam logic [7:0] LCR_RST      = 8'h00;
  localparam logic [7:0] MCR_RST      = 8'h00;
  localparam logic [7:0] DIV_LOW_RST  = 8'h01;
  localparam logic [7:0] DIV_HIGH_RST = 8'h00;
  // Interrupt source codes
  localparam logic [7:0] ISR_NONE     = 8'h01;
  localparam logic [7:0] ISR_TX_EMPTY = 8'h02;
  localparam logic [7:0] ISR_RX_DATA  = 8'h04;
  localparam logic [7:0] ISR_RX_TOUT  = 8'h0c;
  // Timing counts
  localparam logic [1:0] PRESCALE_LAST   = 2'h3;
  localparam int         TICKS_PER_BIT   = 16;
  localparam logic [3:0] TICK_LAST       = 4'hf;
  localparam logic [3:0] TICK_MID        = 4'h7;
  localparam logic [3:0] WORD_BASE       = 4'h5;
  localparam int         TOUT_CHARS      = 4;
  localparam int         TOUT_EXTRA_BITS = 12;
  // FIFO geometry and receive trigger levels
  localparam int         FIFO_DEPTH = 64;
  localparam int         RX_TAG_W   = 3;
  localparam logic [6:0] RX_TRIG0   = 7'h08;
  localparam logic [6:0] RX_TRIG1   = 7'h10;
  localparam logic [6:0] RX_TRIG2   = 7'h38;
  localparam logic [6:0] RX_TRIG3   = 7'h3c;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA  = 5'b00100,
    TX_PAR   = 5'b01000,
    TX_STOP  = 5'b10000
  } ubtrc_tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_PAR   = 5'b01000,
    RX_STOP  = 5'b10000
  } ubtrc_rx_state_t;
endpackage

/* File: ubtrc_fifo_if.sv */
/*
  Carrier between the core and its FIFOs: push side, pop side, fill level
  and flush. Assumes both ends run on clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
interface ubtrc_fifo_if #(parameter int W = 8, parameter int LW = 7);
  logic          in_valid;
  logic          in_ready;
  logic [W-1:0]  in_data;
  logic          out_valid;
  logic          out_ready;
  logic [W-1:0]  out_data;
  logic [LW-1:0] level;
  logic          flush;
  modport fifo (input in_valid, in_data, out_ready, flush,
                output in_ready, out_valid, out_data, level);
  modport user (output in_valid, in_data, out_ready, flush,
                input in_ready, out_valid, out_data, level);
endinterface
`default_nettype wire

/* File: ubtrc_fifo.sv */
/*
  Synchronous FIFO with registered head word; level counts head plus
  memory. Assumes DEPTH is a power of two and one clock.
*/
`timescale 1ns/100ps
`default_nettype none
module ubtrc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 64
) (
  input wire logic   clk_sys, // System clock
  input wire logic   reset,   // Synchronous, active high
  ubtrc_fifo_if.fifo f        // Push, pop and level
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0]   mcnt;
    logic          ovalid;
    logic [W-1:0]  odata;
  } ubtrc_fifo_state_t;

  ubtrc_fifo_state_t s;
  ubtrc_fifo_state_t next_s;
  logic [W-1:0]      mem [DEPTH];
  logic              push;
  logic              take;
  logic              load;

  assign f.level     = (PW+1)'(s.mcnt + (PW+1)'(s.ovalid));
  assign f.in_ready  = f.level < (PW+1)'(DEPTH);
  assign f.out_valid = s.ovalid;
  assign f.out_data  = s.odata;
  assign push        = f.in_valid && f.in_ready;
  assign take        = s.ovalid && f.out_ready;
  assign load        = (s.mcnt != '0) && (!s.ovalid || take);

  always_comb begin
    next_s = s;
    if (take) begin
      next_s.ovalid = 1'b0;
    end
    if (load) begin
      next_s.odata  = mem[s.rd_ptr];
      next_s.ovalid = 1'b1;
      next_s.rd_ptr = s.rd_ptr + 1'b1;
    end
    if (push) begin
      next_s.wr_ptr = s.wr_ptr + 1'b1;
    end
    next_s.mcnt = s.mcnt + (PW+1)'(push) - (PW+1)'(load);
    if (reset || f.flush) begin
      next_s = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    s <= next_s;
    if (push) begin
      mem[s.wr_ptr] <= f.in_data;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_fifo_no_overfill;
    f.level == (PW+1)'(DEPTH) |=> !$past(push);
  endproperty
  a_fifo_no_overfill: assert property (p_fifo_no_overfill) else $error("fifo accepted past full");
endmodule
`default_nettype wire

/* File: ubtrc_core.sv */
/*
  UART channel core: prescaler and rate divider, transmitter with FIFO and
  shifter, receiver with tagged FIFO, line status and interrupt source.
  Assumes register strobes are synchronous to clk_sys; rxd is asynchronous.
*/
// Behaviour
// - Prescaler divides by 1 or 4 per control bit 7
// - Control bit 7 zero selects divide by 1
// - Divisor 1..65535 yields the 16X sampling tick
// - Divisor is high byte over low byte
// - Transmit and receive both run on that tick
// - Each transmitted bit lasts sixteen ticks
// - Frame: start, data, optional parity, stop bits
// - Data bit 0 leaves first
// - Holding register writes push the transmit FIFO
// - Non-FIFO: empty flag on shifter load, interrupt
// - FIFO mode: empty flag and interrupt when drained
// - Shifter-empty flag only when everything is empty
// - Start bit checked eight ticks after falling edge
// - Later bits sampled every sixteen ticks
// - Head byte error tags shown in status bits 2-4
// - Data-ready per character or at trigger level
// - Timeout after four words plus twelve bits
// - Receive interrupts need enable bit 0
// - Receive FIFO holds 64 eleven-bit entries
`timescale 1ns/100ps
`default_nettype none
module ubtrc_core
  import ubtrc_pkg::*;
(
  input  wire logic       clk_sys,  // System clock, also the oscillator input
  input  wire logic       reset,    // Synchronous, active high
  input  wire logic [2:0] addr,     // Register address
  input  wire logic       wr_stb,   // One-cycle register write
  input  wire logic       rd_stb,   // One-cycle register read
  input  wire logic [7:0] wr_data,  // Write data
  output logic      [7:0] rd_data,  // Read data, valid the cycle after rd_stb
  input  wire logic       rxd,      // Serial receive line
  output logic            txd,      // Serial transmit line
  output logic            irq       // Interrupt request, active high
);
  typedef struct packed {
    logic [7:0]      interrupt_enable_reg;
    logic [7:0]      line_control_reg;
    logic [7:0]      modem_control_reg;
    logic [7:0]      dll;
    logic [7:0]      divisor_high;
    logic            fifo_en;
    logic [1:0]      trig;
    logic [1:0]      pre_cnt;
    logic [15:0]     div_cnt;
    logic            tick;
    ubtrc_tx_state_t tx_st;
    logic [3:0]      tx_smp;
    logic [2:0]      tx_bit;
    logic [7:0]      tx_sh;
    logic            tx_par;
    logic            txd;
    logic            thre_d;
    logic            thre_pend;
    ubtrc_rx_state_t rx_st;
    logic [3:0]      rx_smp;
    logic [2:0]      rx_bit;
    logic [7:0]      rx_sh;
    logic            rx_pbit;
    logic            rx_perr;
    logic            rx_s1;
    logic            rx_s2;
    logic            rx_prev;
    logic            overrun;
    logic [9:0]      tout_cnt;
    logic            tout;
    logic [7:0]      rdata;
    logic            irq;
  } ubtrc_state_t;

  ubtrc_state_t s;
  ubtrc_state_t next_s;

  ubtrc_fifo_if #(.W(8), .LW(7))             txf ();
  ubtrc_fifo_if #(.W(8 + RX_TAG_W), .LW(7)) rxf ();

  ubtrc_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_sys (clk_sys),
    .reset   (reset),
    .f       (txf.fifo)
  );
  ubtrc_fifo #(.W(8 + RX_TAG_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_sys (clk_sys),
    .reset   (reset),
    .f       (rxf.fifo)
  );

  function automatic logic [6:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0:    trig_level = RX_TRIG0;
      2'h1:    trig_level = RX_TRIG1;
      2'h2:    trig_level = RX_TRIG2;
      default: trig_level = RX_TRIG3;
    endcase
  endfunction

  logic [15:0] divisor;
  logic        dlab;
  logic        pre_en;
  logic        rx_in;
  logic [3:0]  wl;
  logic [2:0]  last_bit;
  logic [7:0]  wmask;
  logic        thre;
  logic        temt;
  logic        rx_trig;
  logic [7:0]  isr_val;
  logic [2:0]  tags;
  logic [7:0]  lsr_val;
  logic        wr_thr;
  logic        rd_rhr;
  logic        wr_fcr;
  logic        stop_end;
  logic        rx_done;
  logic        rx_room;
  logic [5:0]  tout_bits;
  logic [9:0]  tout_lim;

  assign divisor   = {s.divisor_high, s.dll};
  assign dlab      = s.line_control_reg[LCR_DLAB];
  assign pre_en    = s.modem_control_reg[MCR_PRESCALE] ? (s.pre_cnt == PRESCALE_LAST) : 1'b1;
  assign rx_in     = s.rx_s2;
  assign wl        = WORD_BASE + {2'b00, s.line_control_reg[1:0]};
  assign last_bit  = 3'(wl - 4'h1);
  assign wmask     = ~(8'hff << wl);
  assign thre      = (txf.level == '0);
  assign temt      = thre && (s.tx_st == TX_IDLE);
  assign rx_trig   = s.fifo_en ? (rxf.level >= trig_level(s.trig)) : (rxf.level != '0);
  assign tags      = rxf.out_valid ? rxf.out_data[10:8] : 3'h0;
  assign lsr_val   = {1'b0, temt, thre, tags, s.overrun, rxf.out_valid};
  assign tout_bits = 6'(wl * TOUT_CHARS + TOUT_EXTRA_BITS);
  assign tout_lim  = 10'(tout_bits * TICKS_PER_BIT);
  assign wr_thr    = wr_stb && (addr == ADDR_DATA) && !dlab;
  assign rd_rhr    = rd_stb && (addr == ADDR_DATA) && !dlab;
  assign wr_fcr    = wr_stb && (addr == ADDR_FCR);
  assign stop_end  = s.tick && (s.tx_smp == TICK_LAST) && (s.tx_st == TX_STOP)
                     && !(s.line_control_reg[LCR_STOP2] && (s.tx_bit == 3'h0));
  assign rx_done   = s.tick && (s.rx_smp == TICK_LAST) && (s.rx_st == RX_STOP);
  assign rx_room   = s.fifo_en ? rxf.in_ready : (rxf.level == '0);

  always_comb begin
    if (s.interrupt_enable_reg[IER_RX] && rx_trig) begin
      isr_val = ISR_RX_DATA;
    end else if (s.interrupt_enable_reg[IER_RX] && s.tout) begin
      isr_val = ISR_RX_TOUT;
    end else if (s.interrupt_enable_reg[IER_TX] && s.thre_pend) begin
      isr_val = ISR_TX_EMPTY;
    end else begin
      isr_val = ISR_NONE;
    end
  end

  // Non-FIFO mode keeps a single holding slot
  assign txf.in_valid  = wr_thr && (s.fifo_en ? txf.in_ready : thre);
  assign txf.in_data   = wr_data;
  // Idle load waits for a tick so the start bit is whole
  assign txf.out_ready = txf.out_valid
                         && (((s.tx_st == TX_IDLE) && s.tick) || stop_end);
  assign txf.flush     = wr_fcr && (wr_data[FCR_TX_FLUSH] || (wr_data[FCR_FIFO_EN] != s.fifo_en));
  assign rxf.in_valid  = rx_done && rx_room;
  assign rxf.in_data   = {(s.rx_sh == 8'h00) && !rx_in && !s.rx_pbit, !rx_in, s.rx_perr, s.rx_sh};
  assign rxf.out_ready = rd_rhr;
  assign rxf.flush     = wr_fcr && (wr_data[FCR_RX_FLUSH] || (wr_data[FCR_FIFO_EN] != s.fifo_en));

  always_comb begin
    next_s      = s;
    next_s.tick = 1'b0;
    // Rate generation
    next_s.pre_cnt = s.pre_cnt + 2'h1;
    if (pre_en && (divisor != 16'h0000)) begin
      if (s.div_cnt >= divisor - 16'h0001) begin
        next_s.div_cnt = 16'h0000;
        next_s.tick    = 1'b1;
      end else begin
        next_s.div_cnt = s.div_cnt + 16'h0001;
      end
    end
    // Register writes
    if (wr_stb) begin
      if (addr == ADDR_DATA) begin
        if (dlab) begin
          next_s.dll = wr_data;
        end
      end else if (addr == ADDR_IER) begin
        if (dlab) begin
          next_s.divisor_high = wr_data;
        end else begin
          next_s.interrupt_enable_reg = wr_data;
        end
      end else if (addr == ADDR_FCR) begin
        next_s.fifo_en = wr_data[FCR_FIFO_EN];
        next_s.trig    = wr_data[FCR_TRIG_LSB +: 2];
      end else if (addr == ADDR_LCR) begin
        next_s.line_control_reg = wr_data;
      end else if (addr == ADDR_MCR) begin
        next_s.modem_control_reg = wr_data;
      end
    end
    // Register reads
    if (rd_stb) begin
      if (addr == ADDR_DATA) begin
        next_s.rdata = dlab ? s.dll : (rxf.out_valid ? rxf.out_data[7:0] : 8'h00);
      end else if (addr == ADDR_IER) begin
        next_s.rdata = dlab ? s.divisor_high : s.interrupt_enable_reg;
      end else if (addr == ADDR_FCR) begin
        next_s.rdata = isr_val;
      end else if (addr == ADDR_LCR) begin
        next_s.rdata = s.line_control_reg;
      end else if (addr == ADDR_MCR) begin
        next_s.rdata = s.modem_control_reg;
      end else if (addr == ADDR_LSR) begin
        next_s.rdata = lsr_val;
      end else begin
        next_s.rdata = 8'h00;
      end
    end
    // Transmitter, advanced only on the shared tick
    if (s.tick && (s.tx_st != TX_IDLE)) begin
      next_s.tx_smp = s.tx_smp + 4'h1;
    end
    if (s.tick && (s.tx_smp == TICK_LAST)) begin
      case (s.tx_st)
        TX_START: begin
          next_s.tx_st  = TX_DATA;
          next_s.tx_bit = 3'h0;
          next_s.txd    = s.tx_sh[0];
        end
        TX_DATA: begin
          next_s.tx_sh = s.tx_sh >> 1;
          if (s.tx_bit == last_bit) begin
            next_s.tx_st  = s.line_control_reg[LCR_PAR_EN] ? TX_PAR : TX_STOP;
            next_s.txd    = s.line_control_reg[LCR_PAR_EN] ? s.tx_par : 1'b1;
            next_s.tx_bit = 3'h0;
          end else begin
            next_s.tx_bit = s.tx_bit + 3'h1;
            next_s.txd    = s.tx_sh[1];
          end
        end
        TX_PAR: begin
          next_s.tx_st = TX_STOP;
          next_s.txd   = 1'b1;
        end
        TX_STOP: begin
          if (s.line_control_reg[LCR_STOP2] && (s.tx_bit == 3'h0)) begin
            next_s.tx_bit = 3'h1;
          end else begin
            next_s.tx_st = TX_IDLE;
          end
        end
        default: next_s.txd = 1'b1;
      endcase
    end
    if (txf.out_ready) begin
      next_s.tx_st  = TX_START;
      next_s.txd    = 1'b0;
      next_s.tx_smp = 4'h0;
      next_s.tx_sh  = txf.out_data & wmask;
      next_s.tx_par = ^{txf.out_data & wmask, ~s.line_control_reg[LCR_EVEN]};
    end
    // Transmit-empty event; the set wins over a same-cycle clear
    next_s.thre_d = thre;
    if (wr_thr || (rd_stb && (addr == ADDR_FCR) && (isr_val == ISR_TX_EMPTY))) begin
      next_s.thre_pend = 1'b0;
    end
    if (thre && !s.thre_d) begin
      next_s.thre_pend = 1'b1;
    end
    // Receiver
    next_s.rx_s1   = rxd;
    next_s.rx_s2   = s.rx_s1;
    next_s.rx_prev = s.rx_s2;
    if (s.tick && (s.rx_st != RX_IDLE)) begin
      next_s.rx_smp = s.rx_smp + 4'h1;
    end
    case (s.rx_st)
      RX_IDLE: begin
        if (s.rx_prev && !rx_in) begin
          next_s.rx_st   = RX_START;
          next_s.rx_smp  = 4'h0;
          next_s.rx_sh   = 8'h00;
          next_s.rx_pbit = 1'b0;
          next_s.rx_perr = 1'b0;
        end
      end
      RX_START: begin
        if (s.tick && (s.rx_smp == TICK_MID)) begin
          next_s.rx_st  = rx_in ? RX_IDLE : RX_DATA;
          next_s.rx_smp = 4'h0;
          next_s.rx_bit = 3'h0;
        end
      end
      RX_DATA: begin
        if (s.tick && (s.rx_smp == TICK_LAST)) begin
          next_s.rx_sh[s.rx_bit] = rx_in;
          if (s.rx_bit == last_bit) begin
            next_s.rx_st = s.line_control_reg[LCR_PAR_EN] ? RX_PAR : RX_STOP;
          end else begin
            next_s.rx_bit = s.rx_bit + 3'h1;
          end
        end
      end
      RX_PAR: begin
        if (s.tick && (s.rx_smp == TICK_LAST)) begin
          next_s.rx_st   = RX_STOP;
          next_s.rx_pbit = rx_in;
          next_s.rx_perr = ^{s.rx_sh, rx_in, ~s.line_control_reg[LCR_EVEN]};
        end
      end
      RX_STOP: begin
        if (rx_done) begin
          next_s.rx_st = RX_IDLE;
        end
      end
      default: next_s.rx_st = RX_IDLE;
    endcase
    if (rd_stb && (addr == ADDR_LSR)) begin
      next_s.overrun = 1'b0;
    end
    if (rx_done && !rx_room) begin
      next_s.overrun = 1'b1;
    end
    // Receive timeout
    if (rxf.in_valid || rd_rhr || rxf.flush || (rxf.level == '0)) begin
      next_s.tout_cnt = 10'h000;
      next_s.tout     = 1'b0;
    end else if (s.tick) begin
      if (s.tout_cnt >= tout_lim - 10'h001) begin
        next_s.tout = 1'b1;
      end else begin
        next_s.tout_cnt = s.tout_cnt + 10'h001;
      end
    end
    next_s.irq = (isr_val != ISR_NONE);
    if (reset) begin
      next_s         = '0;
      next_s.interrupt_enable_reg     = IER_RST;
      next_s.line_control_reg     = LCR_RST;
      next_s.modem_control_reg     = MCR_RST;
      next_s.dll     = DIV_LOW_RST;
      next_s.divisor_high     = DIV_HIGH_RST;
      next_s.tx_st   = TX_IDLE;
      next_s.rx_st   = RX_IDLE;
      next_s.txd     = 1'b1;
      next_s.thre_d  = 1'b1;
      next_s.rx_s1   = 1'b1;
      next_s.rx_s2   = 1'b1;
      next_s.rx_prev = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    s <= next_s;
  end

  assign rd_data = s.rdata;
  assign txd     = s.txd;
  assign irq     = s.irq;

  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_pre_div4;
    s.modem_control_reg[MCR_PRESCALE] && pre_en |=> (!pre_en || !s.modem_control_reg[MCR_PRESCALE]) [*3];
  endproperty
  a_pre_div4: assert property (p_pre_div4) else $error("prescaler not dividing by four");

  property p_pre_div1;
    !s.modem_control_reg[MCR_PRESCALE] |-> pre_en;
  endproperty
  a_pre_div1: assert property (p_pre_div1) else $error("prescaler not dividing by one");

  property p_tick_at_div;
    pre_en && (divisor != 16'h0000) && (s.div_cnt == divisor - 16'h0001) |=> s.tick;
  endproperty
  a_tick_at_div: assert property (p_tick_at_div) else $error("rate tick missing at divisor");

  property p_tx_bit_edge;
    $changed(s.txd) |-> $past(txf.out_ready) || $past(s.tick && (s.tx_smp == TICK_LAST));
  endproperty
  a_tx_bit_edge: assert property (p_tx_bit_edge) else $error("transmit bit changed early");

  property p_tx_load;
    txf.out_ready |=> (s.tx_sh == $past(txf.out_data & wmask)) && !s.txd;
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("shifter load wrong");

  property p_thre_pend;
    thre && !s.thre_d |=> s.thre_pend;
  endproperty
  a_thre_pend: assert property (p_thre_pend) else $error("transmit-empty event lost");

  property p_temt;
    rd_stb && (addr == ADDR_LSR) && ((s.tx_st != TX_IDLE) || (txf.level != '0))
      |=> !s.rdata[6];
  endproperty
  a_temt: assert property (p_temt) else $error("shifter-empty flag set while busy");

  property p_false_start;
    (s.rx_st == RX_START) && s.tick && (s.rx_smp == TICK_MID) && rx_in |=> s.rx_st == RX_IDLE;
  endproperty
  a_false_start: assert property (p_false_start) else $error("false start accepted");

  property p_rx_irq_gate;
    !s.interrupt_enable_reg[IER_RX] && !s.interrupt_enable_reg[IER_TX] |=> !s.irq;
  endproperty
  a_rx_irq_gate: assert property (p_rx_irq_gate) else $error("interrupt while disabled");

  property p_tout_needs_data;
    s.tout |-> rxf.level != '0;
  endproperty
  a_tout_needs_data: assert property (p_tout_needs_data) else $error("timeout without data");
endmodule
`default_nettype wire

/* File: ubtrc_remote.sv */
/*
  Remote serial receiver: samples txd at bit centres.
  Assumes the bench gives the bit length in clk_sys cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module ubtrc_remote (
  input  wire logic        clk_sys, // Bench clock
  input  wire logic [15:0] bit_cyc, // Cycles per bit
  input  wire logic [3:0]  nbits,   // Bits kept after start
  input  wire logic        txd,     // Line from the core
  output var  logic [11:0] got,     // Bits after start, first in bit 0
  output var  int          frames,  // Frames captured
  output var  int          t_start  // Cycle count at latest start
);
  int cyc = 0;
  initial frames = 0;
  always @(posedge clk_sys) cyc <= cyc + 1;
  always begin
    @(negedge txd);
    @(negedge clk_sys);
    t_start = cyc;
    repeat (bit_cyc / 2 - 1) @(negedge clk_sys);
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_cyc) @(negedge clk_sys);
      got[i] = txd;
    end
    frames = frames + 1;
  end
endmodule
`default_nettype wire

/* File: tb.sv */
/*
  Self-checking bench for ubtrc_core with the remote receiver model.
  Assumes clk_sys at 100 MHz; frames on rxd are driven here.
*/
`timescale 1ns/100ps
`default_nettype none
module tb
  import ubtrc_pkg::*;
;
  logic        clk_sys    = 1'b0;
  logic        reset      = 1'b1;
  logic [2:0]  addr       = 3'h0;
  logic        wr_stb     = 1'b0;
  logic        rd_stb     = 1'b0;
  logic [7:0]  wr_data    = 8'h00;
  logic [7:0]  rd_data;
  logic        rxd        = 1'b1;
  logic        txd;
  logic        irq;
  logic [15:0] bit_cyc    = 16'h0010;
  logic [3:0]  nbits      = 4'h9;
  logic [11:0] got;
  int          frames;
  int          t_start;
  int          num_errors = 0;
  int          checked    = 0;
  int          cyc        = 0;

  ubtrc_core ubtrc_core_inst (.clk_sys(clk_sys), .reset(reset), .addr(addr),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data), .rd_data(rd_data),
    .rxd(rxd), .txd(txd), .irq(irq));
  ubtrc_remote ubtrc_remote_inst (.clk_sys(clk_sys), .bit_cyc(bit_cyc),
    .nbits(nbits), .txd(txd), .got(got), .frames(frames), .t_start(t_start));

  initial forever #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("Checked %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    addr = a;
    wr_data = d;
    wr_stb = 1'b1;
    @(negedge clk_sys);
    wr_stb = 1'b0;
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(negedge clk_sys);
    addr = a;
    rd_stb = 1'b1;
    @(negedge clk_sys);
    rd_stb = 1'b0;
    chk({8'h00, rd_data}, {8'h00, exp}, what);
  endtask

  // Eight data bits at 16 cycles a bit; lo below 9 is a false start
  task automatic send(input logic [7:0] d, input logic stop, input int lo);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    rxd = 1'b0;
    repeat (lo) @(negedge clk_sys);
    for (int i = 1; i < 10 && lo == 16; i++) begin
      rxd = f[i];
      repeat (16) @(negedge clk_sys);
    end
    rxd = 1'b1;
    repeat (16) @(negedge clk_sys);
  endtask

  // Lets the stop bit finish after the model's last sample when a bit is 16 cycles
  task automatic wait_frames(input int n);
    for (int k = 0; k < 9000 && frames < n; k++)
      @(negedge clk_sys);
    repeat (12) @(negedge clk_sys);
  endtask

  task automatic t_tx();
    logic [11:0] e;
    int          n;
    chk({14'h0, txd, irq}, 16'h0002, "idle lines");
    rdc(ADDR_LSR, 8'h60, "lsr reset");
    wr(ADDR_IER, 8'h02);
    for (int w = 0; w < 4; w++) begin
      n = 5 + w;
      e = 12'h02d & ((12'h001 << n) - 12'h001);
      e = e | ({11'h0, ^e ^ ~w[0]} << n) | (12'h001 << (n + 1));
      nbits = 4'(n + 2);
      wr(ADDR_LCR, {3'h0, w[0], 2'h2, w[1:0]});
      wr(ADDR_DATA, 8'h2d);
      repeat (4) @(negedge clk_sys);
      rdc(ADDR_LSR, 8'h20, "lsr shifting");
      chk({15'h0, irq}, 16'h0001, "irq tx empty");
      rdc(ADDR_FCR, ISR_TX_EMPTY, "isr tx empty");
      wait_frames(w + 1);
      chk({4'h0, got & ((12'h001 << (n + 2)) - 12'h001)}, {4'h0, e}, "frame");
    end
    rdc(ADDR_LSR, 8'h60, "lsr idle");
  endtask

  task automatic t_rx();
    wr(ADDR_LCR, 8'h03);
    send(8'h00, 1'b1, 4);
    rdc(ADDR_LSR, 8'h60, "lsr false start");
    send(8'h3c, 1'b1, 16);
    rdc(ADDR_FCR, ISR_NONE, "isr rx masked");
    wr(ADDR_IER, 8'h01);
    rdc(ADDR_FCR, ISR_RX_DATA, "isr rx data");
    chk({15'h0, irq}, 16'h0001, "irq rx data");
    rdc(ADDR_DATA, 8'h3c, "rx byte");
    wr(ADDR_FCR, 8'h01);
    send(8'h55, 1'b0, 16);
    send(8'h96, 1'b1, 16);
    rdc(ADDR_LSR, 8'h69, "lsr head tags");
    rdc(ADDR_DATA, 8'h55, "rx head");
    rdc(ADDR_LSR, 8'h61, "lsr next tags");
    rdc(ADDR_DATA, 8'h96, "rx next");
    send(8'h5a, 1'b1, 16);
    repeat (600) @(negedge clk_sys);
    rdc(ADDR_FCR, ISR_NONE, "isr early");
    repeat (120) @(negedge clk_sys);
    rdc(ADDR_FCR, ISR_RX_TOUT, "isr timeout");
    rdc(ADDR_DATA, 8'h5a, "rx timed out");
    repeat (800) @(negedge clk_sys);
    rdc(ADDR_FCR, ISR_NONE, "isr empty");
    for (int k = 0; k < 8; k++) begin
      if (k == 7)
        rdc(ADDR_FCR, ISR_NONE, "isr below trigger");
      send(8'h80 | 8'(k), 1'b1, 16);
    end
    rdc(ADDR_FCR, ISR_RX_DATA, "isr at trigger");
    wr(ADDR_FCR, 8'h03);
    rdc(ADDR_LSR, 8'h60, "lsr flushed");
  endtask

  task automatic t_fifo();
    int t0;
    wr(ADDR_LCR, 8'h83);
    wr(ADDR_DATA, 8'h02);
    wr(ADDR_IER, 8'h00);
    wr(ADDR_LCR, 8'h03);
    wr(ADDR_MCR, 8'h80);
    wr(ADDR_IER, 8'h02);
    bit_cyc = 16'h0080;
    nbits = 4'h9;
    wr(ADDR_DATA, 8'h11);
    wr(ADDR_DATA, 8'h22);
    wr(ADDR_DATA, 8'h33);
    rdc(ADDR_LSR, 8'h00, "lsr fifo busy");
    wait_frames(5);
    t0 = t_start;
    wait_frames(7);
    chk(16'(t_start - t0), 16'h0a00, "span");
    chk({7'h0, got[8:0]}, 16'h0133, "last frame");
    rdc(ADDR_FCR, ISR_TX_EMPTY, "isr drained");
    repeat (64) @(negedge clk_sys);
    rdc(ADDR_LSR, 8'h60, "lsr drained");
  endtask

  initial begin
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    t_tx();
    t_rx();
    t_fifo();
    conclude();
  end
endmodule
`default_nettype wire
